//--- src/vfs_persist.sv
// Purpose: Persistence timer declaring a fault after an uninterrupted condition
// Assumes: cond_in already synchronised
// Notes:   Restarts from zero whenever the condition drops
`timescale 1ns/10ps
module vfs_persist #(
	parameter int CYCLES = 100
) (
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	input  wire logic cond_in,
	output logic      expired_out
);
	logic [vfs_pkg::TMR_W-1:0] count;
	logic [vfs_pkg::TMR_W-1:0] next_count;
	logic                      next_expired;
	localparam logic [vfs_pkg::TMR_W-1:0] LIMIT = vfs_pkg::TMR_W'(CYCLES - 1);

	always_comb begin
		next_count = vfs_pkg::TMR_ZERO;
		next_expired = 1'b0;
		if (cond_in) begin
			if (count >= LIMIT) begin
				next_count = count;
				next_expired = 1'b1;
			end else begin
				next_count = count + vfs_pkg::TMR_ONE;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= vfs_pkg::TMR_ZERO;
			expired_out <= 1'b0;
		end else begin
			count <= next_count;
			expired_out <= next_expired;
		end
	end

	chk_drop_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!cond_in |=> !expired_out) else $error("timer expired after drop");
endmodule

//--- src/vfs_pkg.sv
// Purpose: Shared constants and types for the regulator fault supervisor
// Assumes: 100 MHz mclk_in
// Notes:   Comparator flags arrive from analog, asynchronous to mclk_in
package vfs_pkg;

	localparam int CLK_MHZ = 100;
	// Persistence times in microseconds
	localparam int OC_TIME_US = 120;
	localparam int BAL_TIME_US = 1000;
	localparam int UV_TIME_US = 1000;
	localparam int OV1_TIME_US = 1000;
	localparam int OC_CYCLES = OC_TIME_US * CLK_MHZ;
	localparam int BAL_CYCLES = BAL_TIME_US * CLK_MHZ;
	localparam int UV_CYCLES = UV_TIME_US * CLK_MHZ;
	localparam int OV1_CYCLES = OV1_TIME_US * CLK_MHZ;
	localparam int TMR_W = 17;

	// Threshold select codes: band index and phase config
	localparam logic [2:0] BAND_NONE = 3'h0;
	localparam int BAND_COUNT = 8;
	localparam int THR_W = 8;
	// Thresholds in units of 0.01 uA would be too wide; units are 1/3 uA
	// Default: 40 uA two-phase, 60 uA one-phase
	localparam logic [THR_W-1:0] THR_DEF_2PH = 8'h78;
	localparam logic [THR_W-1:0] THR_DEF_1PH = 8'hb4;

	typedef struct packed {
		logic oc;
		logic way_oc;
		logic imbalance;
		logic uv;
		logic ov1;
		logic ov2_high;
		logic ov2_low;
		logic over_temp;
	} vfs_cmp_type;

	typedef struct packed {
		logic oc;
		logic way_oc;
		logic imbalance;
		logic uv;
		logic ov1;
	} vfs_latch_type;

	typedef struct packed {
		logic high_side_on;
		logic low_side_on;
		logic pwm_enable;
	} vfs_gate_type;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SAMPLE,
		ST_SOFT_START,
		ST_RUN,
		ST_LATCHED
	} vfs_state_type;

	localparam logic [TMR_W-1:0] TMR_ZERO = 17'h0_0000;
	localparam logic [TMR_W-1:0] TMR_ONE = 17'h0_0001;
	localparam logic [15:0] SS_CYCLES = 16'h0_400;

endpackage

//--- src/vfs_supervisor.sv
// Purpose: Fault supervision, gate shutdown, power-good and feedback switching
// Assumes: Comparator flags and straps are asynchronous pins, synchronised here
// Notes:   rst_n_in is the supply power-on reset
//
// Functional notes
// - Overcurrent declared after 120 us of continuous excess droop current.
// - Sample resistor band at start-up, hold threshold until regulator off.
// - No resistor: 40 uA two-phase, 60 uA one-phase; else table value.
// - Way-overcurrent at 2.5x: immediate PWM shutoff and power-good low.
// - Sense-input imbalance over 9 mV for 1 ms latches fault.
// - Output 300 mV under target for 1 ms latches undervoltage fault.
// - Output 200 mV over target for 1 ms latches first overvoltage.
// - These faults drop power-good and latch both gates off, tri-state.
// - Latched faults clear only on regulator-on low or supply reset.
// - After clear and re-enable, restart through soft-start.
// - Output above 1.55 V with regulator-on high: immediate second overvoltage, low sides on.
// - Low sides stay on until output under 0.85 V, then all off.
// - Discharge repeats each time output again exceeds 1.55 V while regulator-on is high.
// - Second overvoltage cleared only by supply power-on reset.
// - Second overvoltage detection stays armed even with other faults latched.
// - Thermistor under 1.18 V pulls throttle low, nothing else.
// - Aux feedback switch closed in two-phase mode, open in one-phase.
// - In one-phase configuration the aux switch stays open always.
`timescale 1ns/10ps
module vfs_supervisor (
	input  wire logic                       mclk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       regulator_on_in,
	input  wire logic                       one_phase_cfg_in,
	input  wire logic                       two_phase_mode_in,
	input  wire logic [2:0]                 comp_band_in,
	input  wire vfs_pkg::vfs_cmp_type       cmp_in,
	output logic [vfs_pkg::THR_W-1:0]       oc_threshold_out,
	output vfs_pkg::vfs_gate_type           gate_out,
	output logic                            soft_start_out,
	output logic                            power_good_out,
	output logic                            thermal_throttle_n_out,
	output logic                            aux_feedback_switch_out,
	output logic                            aux_feedback_track_out,
	output vfs_pkg::vfs_latch_type          fault_out,
	output logic                            ov2_fault_out
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = 8 + 1 + 1 + 1 + 3;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] next_sync_a;

	always_comb begin
		next_sync_a = {cmp_in, regulator_on_in, one_phase_cfg_in, two_phase_mode_in,
			comp_band_in};
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= sync_a;
		end
	end

	vfs_pkg::vfs_cmp_type cmp;
	logic                 reg_on;
	logic                 one_phase;
	logic                 two_mode;
	logic [2:0]           band;

	always_comb begin
		{cmp, reg_on, one_phase, two_mode, band} = sync_b;
	end

	// ------------------------------------------------------------
	// Threshold table
	// ------------------------------------------------------------
	// Units of 1/3 uA so every tabulated value is whole
	function automatic logic [vfs_pkg::THR_W-1:0] thr_lookup(input logic [2:0] b,
		input logic one_ph);
		logic [vfs_pkg::THR_W-1:0] t2;
		logic [vfs_pkg::THR_W-1:0] t1;
		t2 = vfs_pkg::THR_DEF_2PH;
		t1 = vfs_pkg::THR_DEF_1PH;
		case (b)
			3'h1: begin t2 = 8'h88; t1 = 8'hcc; end
			3'h2: begin t2 = 8'h7c; t1 = 8'hba; end
			3'h3: begin t2 = 8'h6c; t1 = 8'ha2; end
			3'h4: begin t2 = 8'h70; t1 = 8'hb4; end
			3'h5: begin t2 = 8'h74; t1 = 8'hcc; end
			3'h6: begin t2 = 8'h80; t1 = 8'hba; end
			3'h7: begin t2 = 8'h84; t1 = 8'ha2; end
			default: begin t2 = vfs_pkg::THR_DEF_2PH; t1 = vfs_pkg::THR_DEF_1PH; end
		endcase
		return one_ph ? t1 : t2;
	endfunction

	// ------------------------------------------------------------
	// Persistence timers
	// ------------------------------------------------------------
	logic oc_exp;
	logic bal_exp;
	logic uv_exp;
	logic ov1_exp;
	logic run_ok;

	vfs_persist #(.CYCLES(vfs_pkg::OC_CYCLES)) u_oc (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (cmp.oc && run_ok),
		.expired_out (oc_exp)
	);
	vfs_persist #(.CYCLES(vfs_pkg::BAL_CYCLES)) u_bal (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (cmp.imbalance && run_ok),
		.expired_out (bal_exp)
	);
	vfs_persist #(.CYCLES(vfs_pkg::UV_CYCLES)) u_uv (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (cmp.uv && run_ok),
		.expired_out (uv_exp)
	);
	vfs_persist #(.CYCLES(vfs_pkg::OV1_CYCLES)) u_ov1 (
		.mclk_in     (mclk_in),
		.rst_n_in    (rst_n_in),
		.cond_in     (cmp.ov1 && run_ok),
		.expired_out (ov1_exp)
	);

	// ------------------------------------------------------------
	// Sequencer and latches
	// ------------------------------------------------------------
	vfs_pkg::vfs_state_type    state;
	vfs_pkg::vfs_state_type    next_state;
	vfs_pkg::vfs_latch_type    latch;
	vfs_pkg::vfs_latch_type    next_latch;
	logic                      ov2;
	logic                      next_ov2;
	logic                      discharge;
	logic                      next_discharge;
	logic [vfs_pkg::THR_W-1:0] thr;
	logic [vfs_pkg::THR_W-1:0] next_thr;
	logic [15:0]               ss_count;
	logic [15:0]               next_ss_count;
	logic                      any_fault;

	always_comb begin
		run_ok = (state == vfs_pkg::ST_RUN) || (state == vfs_pkg::ST_SOFT_START);
		any_fault = |latch;
	end

	always_comb begin
		next_state = state;
		next_latch = latch;
		next_ov2 = ov2;
		next_discharge = discharge;
		next_thr = thr;
		next_ss_count = ss_count;
		case (state)
			vfs_pkg::ST_OFF: begin
				if (reg_on) begin
					next_state = vfs_pkg::ST_SAMPLE;
				end
			end
			vfs_pkg::ST_SAMPLE: begin
				next_thr = thr_lookup(band, one_phase);
				next_ss_count = 16'h0_000;
				next_state = vfs_pkg::ST_SOFT_START;
			end
			vfs_pkg::ST_SOFT_START: begin
				next_ss_count = ss_count + 16'h0_001;
				if (ss_count == vfs_pkg::SS_CYCLES) begin
					next_state = vfs_pkg::ST_RUN;
				end
			end
			vfs_pkg::ST_RUN: begin
				if (any_fault) begin
					next_state = vfs_pkg::ST_LATCHED;
				end
			end
			vfs_pkg::ST_LATCHED: begin
				next_state = vfs_pkg::ST_LATCHED;
			end
			default: next_state = vfs_pkg::ST_OFF;
		endcase
		if (run_ok) begin
			next_latch.oc = latch.oc | oc_exp;
			next_latch.way_oc = latch.way_oc | cmp.way_oc;
			next_latch.imbalance = latch.imbalance | bal_exp;
			next_latch.uv = latch.uv | uv_exp;
			next_latch.ov1 = latch.ov1 | ov1_exp;
			if (|next_latch) begin
				next_state = vfs_pkg::ST_LATCHED;
			end
		end
		if (!reg_on) begin
			next_latch = '0;
			next_state = vfs_pkg::ST_OFF;
		end
		if (reg_on && cmp.ov2_high) begin
			next_ov2 = 1'b1;
			next_discharge = 1'b1;
		end else if (discharge && cmp.ov2_low) begin
			next_discharge = 1'b0;
		end
		if (next_ov2) begin
			next_state = (next_state == vfs_pkg::ST_OFF) ? vfs_pkg::ST_OFF
				: vfs_pkg::ST_LATCHED;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= vfs_pkg::ST_OFF;
			latch <= '0;
			ov2 <= 1'b0;
			discharge <= 1'b0;
			thr <= vfs_pkg::THR_DEF_2PH;
			ss_count <= 16'h0_000;
		end else begin
			state <= next_state;
			latch <= next_latch;
			ov2 <= next_ov2;
			discharge <= next_discharge;
			thr <= next_thr;
			ss_count <= next_ss_count;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	vfs_pkg::vfs_gate_type next_gate;
	logic                  next_pg;
	logic                  next_tt_n;
	logic                  next_aux_sw;

	always_comb begin
		next_gate = '0;
		next_pg = 1'b0;
		if (discharge) begin
			next_gate.low_side_on = 1'b1;
		end else if (!ov2 && !any_fault && (next_latch == '0) && run_ok) begin
			next_gate.pwm_enable = 1'b1;
			next_gate.high_side_on = 1'b1;
			next_gate.low_side_on = 1'b1;
			next_pg = (state == vfs_pkg::ST_RUN);
		end
		next_tt_n = !cmp.over_temp;
		next_aux_sw = two_mode && !one_phase;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gate_out <= '0;
			power_good_out <= 1'b0;
			thermal_throttle_n_out <= 1'b1;
			aux_feedback_switch_out <= 1'b0;
		end else begin
			gate_out <= next_gate;
			power_good_out <= next_pg;
			thermal_throttle_n_out <= next_tt_n;
			aux_feedback_switch_out <= next_aux_sw;
		end
	end

	always_comb begin
		oc_threshold_out = thr;
		soft_start_out = (state == vfs_pkg::ST_SOFT_START);
		aux_feedback_track_out = 1'b1;
		fault_out = latch;
		ov2_fault_out = ov2;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_ov2_hit;
		reg_on && cmp.ov2_high;
	endsequence
	sequence s_discharge;
		discharge && !cmp.ov2_low;
	endsequence

	chk_way_oc_fast: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		run_ok && cmp.way_oc |=> ##1 !gate_out.pwm_enable && !power_good_out)
		else $error("way overcurrent did not shut off");
	chk_fault_gates: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		any_fault && !discharge |=> gate_out == '0 && !power_good_out)
		else $error("fault did not turn gates off");
	chk_latch_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		(latch != '0) && reg_on |=> $stable(latch))
		else $error("latched fault cleared while on");
	chk_ov2_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ov2 |=> ov2)
		else $error("second overvoltage cleared");
	chk_ov2_low_on: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_ov2_hit |=> ov2 && discharge ##1 gate_out.low_side_on)
		else $error("discharge not started");
	chk_discharge_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_discharge |=> gate_out.low_side_on)
		else $error("low sides dropped during discharge");
	chk_ov2_armed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		any_fault ##0 s_ov2_hit |=> ov2 && discharge)
		else $error("second overvoltage not armed");
	chk_discharge_end: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		discharge && cmp.ov2_low && !cmp.ov2_high |=> ##1 gate_out == '0)
		else $error("gates not off after discharge");
	chk_throttle: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(cmp.over_temp) |=> !thermal_throttle_n_out)
		else $error("throttle not asserted");
	chk_aux_open: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		one_phase |=> !aux_feedback_switch_out)
		else $error("aux switch closed in one-phase");
	chk_thr_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		state != vfs_pkg::ST_SAMPLE |=> $stable(thr))
		else $error("threshold changed outside sampling");
endmodule

//--- tb/vfs_plant.sv
// Purpose: Power stage and host side model producing comparator flags
// Assumes: Levels in mV, droop current in 1/3 uA units
// Notes:   Output discharges while the low sides conduct and the high sides are off
`timescale 1ns/10ps
module vfs_plant (
	input  wire logic                  mclk_in,
	input  wire vfs_pkg::vfs_gate_type gate_in,
	input  wire logic [7:0]            thr_in,
	input  wire logic                  load_in,
	input  wire logic [15:0]           load_mv_in,
	input  wire logic [15:0]           vid_mv_in,
	input  wire logic [15:0]           idroop_in,
	input  wire logic [15:0]           phase_current_sense_diff_in,
	input  wire logic [15:0]           ntc_mv_in,
	output vfs_pkg::vfs_cmp_type       cmp_out
);
	logic [15:0] vout_mv;

	// -------------------------------------------------
	// Output node
	// -------------------------------------------------
	// Low side crowbar discharge
	always_ff @(posedge mclk_in) begin
		if (load_in) begin
			vout_mv <= load_mv_in;
		end else if (gate_in.low_side_on && !gate_in.high_side_on
			&& vout_mv > 16'h0002) begin
			vout_mv <= vout_mv - 16'h0002;
		end
	end

	// -------------------------------------------------
	// Comparators
	// -------------------------------------------------
	// Comparator levels
	always_comb begin
		cmp_out.oc = idroop_in > {8'h00, thr_in};
		cmp_out.way_oc = 2 * idroop_in > 5 * {8'h00, thr_in};
		cmp_out.imbalance = phase_current_sense_diff_in > 16'h0009;
		cmp_out.uv = vout_mv + 16'h012c <= vid_mv_in;
		cmp_out.ov1 = vout_mv > vid_mv_in + 16'h00c8;
		cmp_out.ov2_high = vout_mv > 16'h060e;
		cmp_out.ov2_low = vout_mv < 16'h0352;
		cmp_out.over_temp = ntc_mv_in < 16'h049c;
	end
endmodule

//--- tb/vfs_supervisor_tb.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: 100 MHz clock, inputs driven on the falling edge
// Notes:   One-millisecond timers are only checked for early trips
`timescale 1ns/10ps
module vfs_supervisor_tb;
	localparam logic [7:0] THR2 [8] = '{8'h78, 8'h88, 8'h7c, 8'h6c, 8'h70, 8'h74, 8'h80, 8'h84};
	localparam logic [7:0] THR1 [8] = '{8'hb4, 8'hcc, 8'hba, 8'ha2, 8'hb4, 8'hcc, 8'hba, 8'ha2};

	logic                  mclk_in, rst_n_in, regulator_on_in, one_ph, two_ph_mode;
	logic [2:0]            band;
	vfs_pkg::vfs_cmp_type  cmp;
	logic [7:0]            thr;
	vfs_pkg::vfs_gate_type gate;
	logic                  soft_start, pg, tt_n, aux_sw, aux_trk, ov2;
	vfs_pkg::vfs_latch_type fault;
	logic                  load;
	logic [15:0]           load_mv, vid_mv, idroop, phase_current_sense_diff, ntc_mv;
	int                    error_cnt, n_tests, seed, i;

	vfs_supervisor i_vfs_supervisor (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .regulator_on_in(regulator_on_in),
		.one_phase_cfg_in(one_ph), .two_phase_mode_in(two_ph_mode), .comp_band_in(band),
		.cmp_in(cmp), .oc_threshold_out(thr), .gate_out(gate), .soft_start_out(soft_start),
		.power_good_out(pg), .thermal_throttle_n_out(tt_n), .aux_feedback_switch_out(aux_sw),
		.aux_feedback_track_out(aux_trk), .fault_out(fault), .ov2_fault_out(ov2));

	vfs_plant i_vfs_plant (
		.mclk_in(mclk_in), .gate_in(gate), .thr_in(thr), .load_in(load), .load_mv_in(load_mv),
		.vid_mv_in(vid_mv), .idroop_in(idroop), .phase_current_sense_diff_in(phase_current_sense_diff), .ntc_mv_in(ntc_mv),
		.cmp_out(cmp));

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	function automatic logic [7:0] thr_exp(input logic [2:0] b, input logic one);
		return one ? THR1[b] : THR2[b];
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic start_up();
		int n;
		int k;
		n = 0;
		k = 0;
		regulator_on_in = 1'b1;
		while (soft_start !== 1'b1 && k < 50) begin
			cyc(1);
			k++;
		end
		while (soft_start === 1'b1 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk(16'(n), 16'h0401);
		cyc(2);
		chk(16'(pg), 16'h0001);
	endtask

	task automatic stop_reg();
		regulator_on_in = 1'b0;
		cyc(6);
	endtask

	task automatic set_vout(input logic [15:0] mv);
		load_mv = mv;
		load = 1'b1;
		cyc(1);
		load = 1'b0;
	endtask

	// -------------------------------------------------
	// Clock and watchdog
	// -------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	initial begin
		#(80000 * 10);
		error_cnt++;
		end_of_test();
	end

	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial begin
		seed = 52;
		error_cnt = 0;
		n_tests = 0;
		rst_n_in = 1'b0;
		regulator_on_in = 1'b0;
		one_ph = 1'b0;
		two_ph_mode = 1'b1;
		band = 3'h0;
		load = 1'b1;
		load_mv = 16'h044c;
		vid_mv = 16'h044c;
		idroop = 16'h0000;
		phase_current_sense_diff = 16'h0000;
		ntc_mv = 16'h05dc;
		cyc(8);
		chk(16'({tt_n, pg, aux_trk, ov2}), 16'h000a);
		chk({thr, 3'h0, fault}, 16'h7800);
		cyc(8);
		rst_n_in = 1'b1;
		load = 1'b0;
		cyc(2);
		for (i = 0; i < 16; i++) begin
			band = i[2:0];
			one_ph = i[3];
			two_ph_mode = 1'($random(seed));
			start_up();
			chk(16'(thr), 16'(thr_exp(i[2:0], i[3])));
			band = 3'($random(seed));
			cyc(6);
			chk(16'(thr), 16'(thr_exp(i[2:0], i[3])));
			chk(16'(aux_sw), 16'(!i[3] && two_ph_mode));
			two_ph_mode = !two_ph_mode;
			cyc(6);
			chk(16'(aux_sw), 16'(!i[3] && two_ph_mode));
			ntc_mv = 16'(1000 + ($random(seed) & 511));
			cyc(6);
			chk(16'(tt_n), 16'(ntc_mv >= 16'h049c));
			chk(16'({pg, gate.high_side_on, fault}), 16'h0060);
			chk(16'(pg), 16'h0001);
			ntc_mv = 16'h05dc;
			stop_reg();
		end
		band = 3'h0;
		one_ph = 1'b0;
		start_up();
		idroop = 16'h0079;
		cyc(6000);
		idroop = 16'h0000;
		cyc(5);
		chk(16'(fault), 16'h0000);
		idroop = 16'h0079;
		cyc(vfs_pkg::OC_CYCLES - 20);
		chk(16'(fault.oc), 16'h0000);
		cyc(40);
		chk(16'(fault.oc), 16'h0001);
		chk({13'h0000, gate}, 16'h0000);
		chk(16'(pg), 16'h0000);
		idroop = 16'h0000;
		cyc(20);
		chk(16'(fault.oc), 16'h0001);
		stop_reg();
		chk(16'(fault), 16'h0000);
		start_up();
		phase_current_sense_diff = 16'h0014;
		for (i = 0; i < 2; i++) begin
			set_vout(i ? 16'h0578 : 16'h02bc);
			cyc(3000);
			chk(16'(fault), 16'h0000);
			chk(16'(pg), 16'h0001);
		end
		phase_current_sense_diff = 16'h0000;
		set_vout(16'h044c);
		idroop = 16'h012c;
		cyc(10);
		chk(16'(fault.way_oc), 16'h0000);
		idroop = 16'h012d;
		cyc(6);
		chk(16'(fault.way_oc), 16'h0001);
		chk({13'h0000, gate}, 16'h0000);
		chk(16'(pg), 16'h0000);
		idroop = 16'h0000;
		set_vout(16'h0640);
		cyc(5);
		chk(16'({ov2, gate.low_side_on, pg}), 16'h0006);
		cyc(355);
		chk(16'(gate.low_side_on), 16'h0001);
		cyc(30);
		chk({13'h0000, gate}, 16'h0000);
		set_vout(16'h0640);
		cyc(5);
		chk(16'(gate.low_side_on), 16'h0001);
		cyc(400);
		stop_reg();
		set_vout(16'h044c);
		regulator_on_in = 1'b1;
		cyc(1200);
		chk(16'({ov2, pg}), 16'h0002);
		rst_n_in = 1'b0;
		regulator_on_in = 1'b0;
		cyc(4);
		chk(16'(ov2), 16'h0000);
		rst_n_in = 1'b1;
		cyc(2);
		start_up();
		end_of_test();
	end
endmodule
